//--- core/urio_ctrl.sv
// Unit-record control: printer, card reader and card punch sequencing.
`timescale 1ns/100ps
`include "urio_cfg.svh"
module urio_ctrl #(
  parameter bit COLS90 = 1'b0,
  parameter int RDR_CYCLE_CYC = `URIO_RDR_CYCLE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Instruction from the processor
  input wire logic instrValid,
  input wire logic [29:0] instrWord,
  output logic instrTaken,
  output logic procHold,
  output logic testInd43_q,
  output logic irqPrt_q,
  output logic irqRdr_q,
  output logic irqPun_q,
  // Control word access
  output logic twReq,
  output logic twWe,
  output logic [6:0] twGroup,
  output logic [23:0] twWdata,
  input wire logic [23:0] twRdata,
  input wire logic twAck,
  // Character memory access
  output logic memReq_q,
  output logic memWe_q,
  output logic [17:0] memAddr_q,
  output logic [5:0] memWdata_q,
  input wire logic [5:0] memRdata,
  input wire logic memAck,
  input wire logic memParityErr,
  input wire logic memOverload,
  // Printer mechanism
  input wire logic prtReady,
  input wire logic prtPaperLow,
  input wire logic prtManualBtn,
  input wire logic prtWheelErr,
  output logic prtAdvStart_q,
  output logic [5:0] prtAdvLines_q,
  input wire logic prtAdvDone,
  output logic prtDataValid,
  input wire logic prtDataReady,
  // Card reader mechanism
  input wire logic rdrReady,
  input wire logic rdrRegErr,
  input wire logic rdrTwoCards,
  input wire logic rdrSolarErr,
  output logic rdrFeed_q,
  output logic rdrXlate_q,
  input wire logic [5:0] rdrChar,
  input wire logic rdrCharValid,
  output logic rdrCharReady,
  // Card punch mechanism
  input wire logic punReady,
  input wire logic punHoleErr,
  output logic punAdvance_q,
  output logic punXlate_q,
  output logic punDataValid,
  input wire logic punDataReady,
  output logic punStack_q,
  output logic punStackSel1_q,
  output logic [3:0] punOcc_q,
  // Shared outbound character and indicator state
  output logic [5:0] devData_q,
  output logic [11:0] prtInd,
  output logic [11:0] rdrInd,
  output logic [11:0] punInd
);
  urio_pkg::urio_state_t state_q, state_d;
  urio_pkg::urio_unit_t unit_q;
  logic rstMeta_q, rstSyncB_q;
  logic [5:0] fn_q;
  logic [11:0] det_q;
  logic doPrint_q, dValid_q, holeFail_q, rdrCycEn_q;
  logic [17:0] base_q, nextBase_q;
  logic [7:0] idx_q;

  // Reset leaves through two flops so release is clean on clk_sys.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSyncB_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncB_q <= rstMeta_q;
    end
  end

  // Instruction field decode.
  logic [5:0] opF, fnF;
  logic [2:0] chF, unitF, fnLow;
  logic [11:0] detF;
  logic isXf, chPrt, chRdr, chPun, fnTest, fnReset;
  assign opF = instrWord[`URIO_OP_HI:`URIO_OP_LO];
  assign chF = instrWord[`URIO_CH_HI:`URIO_CH_LO];
  assign unitF = instrWord[`URIO_UNIT_HI:`URIO_UNIT_LO];
  assign fnF = instrWord[`URIO_FN_HI:`URIO_FN_LO];
  assign detF = instrWord[`URIO_DET_HI:`URIO_DET_LO];
  assign fnLow = fnF[2:0];
  assign instrTaken = instrValid && !procHold;
  assign isXf = instrTaken && (opF == `URIO_OP_XF);
  assign chPrt = isXf && (chF == `URIO_CH_PRT);
  assign chRdr = isXf && (chF == `URIO_CH_RDR);
  assign chPun = isXf && (chF == `URIO_CH_PUN);
  assign fnTest = fnF == `URIO_FN_TEST;
  assign fnReset = fnF == `URIO_FN_RESET;

  // Operation requests per peripheral and their acceptance.
  logic prtOp, rdrOp, punOp, rdrStop, engIdle;
  logic prtOk, rdrOk, punOk, startPrt, startRdr, startPun;
  logic prtManualNow, prtInhibit;
  assign prtOp = chPrt && ((fnLow == `URIO_LOW_PRT_ADV) ||
    (fnLow == `URIO_LOW_PRT_PRINT));
  assign rdrOp = chRdr && (fnLow == `URIO_LOW_RDR_READ);
  assign rdrStop = chRdr && (fnF == `URIO_FN_RDR_STOP);
  assign punOp = chPun && ((fnLow == `URIO_LOW_PUN_PUNCH) ||
    (fnLow == `URIO_LOW_PUN_SKIP));
  assign engIdle = state_q == urio_pkg::ST_IDLE;
  assign prtOk = (unitF == 3'h0) && prtReady;
  assign rdrOk = (unitF == 3'h0) && rdrReady;
  assign punOk = (unitF == 3'h0) && punReady;
  assign startPrt = prtOp && prtOk && engIdle;
  assign startRdr = rdrOp && rdrOk && engIdle;
  assign startPun = punOp && punOk && engIdle;
  assign prtManualNow = detF[`URIO_DT_MANUAL];
  // Paper-low blocks printing unless the manual print code bypasses it.
  assign prtInhibit = prtPaperLow && !prtManualNow;

  // Transfer geometry for the unit that owns the engine.
  logic isPrt, isRdr, isPun, xl, manual, advOpt, rdDir, devReady;
  logic xferStep, xferLast, xferDone;
  logic [7:0] cardLen, xferLen, baseInc;
  assign isPrt = unit_q == urio_pkg::UNIT_PRT;
  assign isRdr = unit_q == urio_pkg::UNIT_RDR;
  assign isPun = unit_q == urio_pkg::UNIT_PUN;
  assign xl = det_q[`URIO_DT_XLATE] && !COLS90;
  assign manual = isPrt && det_q[`URIO_DT_MANUAL];
  assign advOpt = det_q[`URIO_DT_ADVBASE] && !manual;
  assign cardLen = COLS90 ? `URIO_LEN_C90 :
    (xl ? `URIO_LEN_C80 : `URIO_LEN_C160);
  assign xferLen = isPrt ? (det_q[`URIO_DT_HALF] ? `URIO_LEN_HALF :
    `URIO_LEN_FULL) : cardLen;
  assign baseInc = isRdr ? ((COLS90 || xl) ? `URIO_INC_128 :
    `URIO_INC_192) : xferLen;
  assign rdDir = !isRdr;
  assign devReady = isPrt ? prtDataReady : punDataReady;
  assign xferStep = rdDir ? (dValid_q && devReady) : (memReq_q && memAck);
  assign xferLast = idx_q == (xferLen - 8'h01);
  assign xferDone = (state_q == urio_pkg::ST_XFER) && xferStep && xferLast;
  assign prtDataValid = dValid_q && isPrt;
  assign punDataValid = dValid_q && isPun;
  assign rdrCharReady = (state_q == urio_pkg::ST_XFER) && isRdr && !memReq_q;

  // Control word requests follow the sequencer state.
  logic [6:0] baseGrp;
  assign baseGrp = isPrt ? `URIO_GRP_PRT_BASE :
    (isRdr ? `URIO_GRP_RDR_BASE : `URIO_GRP_PUN_BASE);
  assign twReq = (state_q == urio_pkg::ST_RD_AUX) ||
    (state_q == urio_pkg::ST_RD_BASE) || (state_q == urio_pkg::ST_RD_SBY) ||
    (state_q == urio_pkg::ST_WR_BASE);
  assign twWe = state_q == urio_pkg::ST_WR_BASE;
  assign twGroup = (state_q == urio_pkg::ST_RD_AUX) ? `URIO_GRP_PRT_ADV :
    ((state_q == urio_pkg::ST_RD_SBY) ? `URIO_GRP_RDR_SBY : baseGrp);
  assign twWdata = {6'h00, nextBase_q};
  // The processor stalls only for operations without the continue option.
  assign procHold = !engIdle && !fn_q[`URIO_FN_CONT];

  // Sequencer next state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      urio_pkg::ST_IDLE: begin
        if (startPrt) begin
          state_d = (prtManualNow && fnLow == `URIO_LOW_PRT_PRINT) ?
            urio_pkg::ST_RD_BASE : urio_pkg::ST_RD_AUX;
        end else if (startRdr) begin
          state_d = urio_pkg::ST_RD_BASE;
        end else if (startPun) begin
          state_d = (fnLow == `URIO_LOW_PUN_PUNCH) ?
            urio_pkg::ST_RD_BASE : urio_pkg::ST_FINISH;
        end
      end
      urio_pkg::ST_RD_AUX: begin
        if (twAck) begin
          state_d = urio_pkg::ST_ADV;
        end
      end
      urio_pkg::ST_ADV: begin
        // Paper moves before a print transfer starts; a manual print skips the advance.
        if (prtAdvDone) begin
          state_d = doPrint_q ? urio_pkg::ST_RD_BASE :
            urio_pkg::ST_FINISH;
        end
      end
      urio_pkg::ST_RD_BASE: begin
        if (twAck) begin
          state_d = urio_pkg::ST_XFER;
        end
      end
      urio_pkg::ST_XFER: begin
        if (xferDone) begin
          if (advOpt) begin
            state_d = urio_pkg::ST_WR_BASE;
          end else if (isRdr) begin
            state_d = urio_pkg::ST_RD_SBY;
          end else begin
            state_d = urio_pkg::ST_FINISH;
          end
        end
      end
      urio_pkg::ST_RD_SBY: begin
        if (twAck) begin
          state_d = urio_pkg::ST_WR_BASE;
        end
      end
      urio_pkg::ST_WR_BASE: begin
        if (twAck) begin
          state_d = urio_pkg::ST_FINISH;
        end
      end
      default: begin
        state_d = urio_pkg::ST_IDLE;
      end
    endcase
  end

  // Latch the accepted operation.
  always_ff @(posedge clk_sys or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      state_q <= urio_pkg::ST_IDLE;
      unit_q <= urio_pkg::UNIT_PRT;
      fn_q <= 6'h00;
      det_q <= 12'h000;
      doPrint_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (startPrt || startRdr || startPun) begin
        unit_q <= startPrt ? urio_pkg::UNIT_PRT :
          (startRdr ? urio_pkg::UNIT_RDR : urio_pkg::UNIT_PUN);
        fn_q <= fnF;
        det_q <= detF;
        doPrint_q <= (fnLow == `URIO_LOW_PRT_PRINT) && !prtInhibit;
      end
    end
  end

  // Base address bookkeeping in control words.
  always_ff @(posedge clk_sys or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      base_q <= 18'h00000;
      nextBase_q <= 18'h00000;
      prtAdvLines_q <= 6'h00;
    end else begin
      if (state_q == urio_pkg::ST_RD_AUX && twAck) begin
        prtAdvLines_q <= twRdata[5:0];
      end
      if (state_q == urio_pkg::ST_RD_BASE && twAck) begin
        base_q <= twRdata[17:0];
      end
      if (xferDone) begin
        nextBase_q <= base_q + {10'h000, baseInc};
      end else if (state_q == urio_pkg::ST_RD_SBY && twAck) begin
        nextBase_q <= twRdata[17:0];
      end
    end
  end

  // Character mover between memory and the mechanism.
  always_ff @(posedge clk_sys or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      idx_q <= 8'h00;
      memReq_q <= 1'b0;
      memWe_q <= 1'b0;
      memAddr_q <= 18'h00000;
      memWdata_q <= 6'h00;
      devData_q <= 6'h00;
      dValid_q <= 1'b0;
    end else if (state_q == urio_pkg::ST_RD_BASE) begin
      idx_q <= 8'h00;
    end else if (state_q == urio_pkg::ST_XFER) begin
      if (rdDir && !memReq_q && !dValid_q) begin
        memReq_q <= 1'b1;
        memWe_q <= 1'b0;
        memAddr_q <= base_q + {10'h000, idx_q};
      end else if (rdDir && memReq_q && memAck) begin
        memReq_q <= 1'b0;
        devData_q <= memRdata;
        dValid_q <= 1'b1;
      end else if (!rdDir && rdrCharValid && rdrCharReady) begin
        memReq_q <= 1'b1;
        memWe_q <= 1'b1;
        memWdata_q <= rdrChar;
        memAddr_q <= base_q + {10'h000, idx_q};
      end else if (!rdDir && memReq_q && memAck) begin
        memReq_q <= 1'b0;
        memWe_q <= 1'b0;
      end
      if (rdDir && dValid_q && devReady) begin
        dValid_q <= 1'b0;
      end
      if (xferStep) begin
        idx_q <= idx_q + 8'h01;
      end
    end
  end

  // Mechanism strobes, reader cyclic enable and completion interrupts.
  logic rdrWrap, finish;
  assign finish = state_q == urio_pkg::ST_FINISH;
  always_ff @(posedge clk_sys or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      prtAdvStart_q <= 1'b0;
      rdrFeed_q <= 1'b0;
      rdrXlate_q <= 1'b0;
      rdrCycEn_q <= 1'b0;
      irqPrt_q <= 1'b0;
      irqRdr_q <= 1'b0;
      irqPun_q <= 1'b0;
    end else begin
      prtAdvStart_q <= (state_q == urio_pkg::ST_RD_AUX) && twAck;
      rdrFeed_q <= startRdr;
      if (startRdr) begin
        rdrXlate_q <= detF[`URIO_DT_XLATE] && !COLS90;
      end
      // A stop takes effect before the request due at this cycle end.
      if (rdrStop) begin
        rdrCycEn_q <= 1'b0;
      end else if (startRdr) begin
        rdrCycEn_q <= fnF[`URIO_FN_IRQ];
      end
      irqPrt_q <= finish && isPrt && fn_q[`URIO_FN_IRQ];
      irqRdr_q <= (finish && isRdr && fn_q[`URIO_FN_IRQ]) ||
        (rdrWrap && rdrCycEn_q && !rdrStop);
      irqPun_q <= finish && isPun && fn_q[`URIO_FN_IRQ];
    end
  end

  // Reader mechanical cycle timer; a long count, so it is a parameter.
  urio_cyc_timer #(
    .CYC(RDR_CYCLE_CYC)
  ) u_rdrCycle (
    .clk_sys(clk_sys),
    .rst_b(rstSyncB_q),
    .run(rdrCycEn_q || (!engIdle && isRdr)),
    .wrap(rdrWrap)
  );

  // Punch track: every punch instruction moves every station by one.
  always_ff @(posedge clk_sys or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      punOcc_q <= 4'h0;
      punAdvance_q <= 1'b0;
      punStack_q <= 1'b0;
      punStackSel1_q <= 1'b0;
      punXlate_q <= 1'b0;
      holeFail_q <= 1'b0;
    end else begin
      punAdvance_q <= startPun;
      punStack_q <= startPun && punOcc_q[3];
      if (startPun) begin
        punOcc_q <= {punOcc_q[2:0], 1'b1};
        punXlate_q <= detF[`URIO_DT_XLATE] && !COLS90;
        // Stacker 1 on a hole-count failure or when this one asks.
        // A hole-count failure seen in this very cycle still counts.
        punStackSel1_q <= detF[`URIO_DT_STK1] || holeFail_q ||
          (punHoleErr && punOcc_q[3]);
        holeFail_q <= 1'b0;
      end else if (punHoleErr && punOcc_q[3]) begin
        holeFail_q <= 1'b1;
      end
    end
  end

  // Indicator events per unit; memory faults go to the active unit.
  logic [11:0] prtSet, rdrSet, punSet, zero12;
  logic memPar, memOvl, prtHit, rdrHit, punHit;
  assign zero12 = 12'h000;
  assign memPar = memParityErr && !engIdle;
  assign memOvl = memOverload && !engIdle;
  always_comb begin
    prtSet = zero12;
    prtSet[`URIO_IND_PAPER] = prtPaperLow;
    prtSet[`URIO_IND_MANBTN] = prtManualBtn;
    prtSet[`URIO_IND_WHEEL] = prtWheelErr;
    prtSet[`URIO_IND_PARITY] = memPar && isPrt;
    prtSet[`URIO_IND_NOTRDY] = prtOp && !prtOk;
    prtSet[`URIO_IND_BUSY] = prtOp && prtOk && !engIdle;
    prtSet[`URIO_IND_OVLD] = memOvl && isPrt;
    rdrSet = zero12;
    rdrSet[`URIO_IND_REG] = rdrRegErr;
    rdrSet[`URIO_IND_TWO] = rdrTwoCards;
    rdrSet[`URIO_IND_FED] = rdrWrap && !engIdle && isRdr;
    rdrSet[`URIO_IND_SOLAR] = rdrSolarErr;
    rdrSet[`URIO_IND_PARITY] = memPar && isRdr;
    rdrSet[`URIO_IND_NOTRDY] = rdrOp && !rdrOk;
    rdrSet[`URIO_IND_BUSY] = rdrOp && rdrOk && !engIdle;
    rdrSet[`URIO_IND_OVLD] = memOvl && isRdr;
    punSet = zero12;
    punSet[`URIO_IND_HOLE] = punHoleErr && punOcc_q[3];
    punSet[`URIO_IND_PARITY] = memPar && isPun;
    punSet[`URIO_IND_NOTRDY] = punOp && !punOk;
    punSet[`URIO_IND_BUSY] = punOp && punOk && !engIdle;
    punSet[`URIO_IND_OVLD] = memOvl && isPun;
  end

  // One sticky bank per unit; detail bits select any combination.
  urio_ind_bank #(.W(12), .VALID(`URIO_VALID_PRT)) u_prtInd (
    .clk_sys(clk_sys),
    .rst_b(rstSyncB_q),
    .setVec(prtSet),
    .clrEn(chPrt && fnReset),
    .selMask(detF),
    .ind_q(prtInd),
    .hit(prtHit)
  );
  urio_ind_bank #(.W(12), .VALID(`URIO_VALID_RDR)) u_rdrInd (
    .clk_sys(clk_sys),
    .rst_b(rstSyncB_q),
    .setVec(rdrSet),
    .clrEn(chRdr && fnReset),
    .selMask(detF),
    .ind_q(rdrInd),
    .hit(rdrHit)
  );
  urio_ind_bank #(.W(12), .VALID(`URIO_VALID_PUN)) u_punInd (
    .clk_sys(clk_sys),
    .rst_b(rstSyncB_q),
    .setVec(punSet),
    .clrEn(chPun && fnReset),
    .selMask(detF),
    .ind_q(punInd),
    .hit(punHit)
  );

  // Testable indicator 43 follows the latest test function.
  always_ff @(posedge clk_sys or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      testInd43_q <= 1'b0;
    end else if (isXf && fnTest) begin
      testInd43_q <= (chPrt && prtHit) || (chRdr && rdrHit) ||
        (chPun && punHit);
    end
  end
endmodule // urio_ctrl

//--- core/urio_cfg.svh
// Constants for the unit-record input-output control: fields, codes, timing.
`ifndef URIO_CFG_SVH
`define URIO_CFG_SVH

// Instruction word field positions.
`define URIO_OP_HI 29
`define URIO_OP_LO 24
`define URIO_CH_HI 23
`define URIO_CH_LO 21
`define URIO_UNIT_HI 20
`define URIO_UNIT_LO 18
`define URIO_FN_HI 17
`define URIO_FN_LO 12
`define URIO_DET_HI 11
`define URIO_DET_LO 0

// Operation code (octal 40) and channel codes.
`define URIO_OP_XF 6'h20
`define URIO_CH_PRT 3'h0
`define URIO_CH_RDR 3'h1
`define URIO_CH_PUN 3'h2

// Function codes (octal 00, 040, 020) and the low-digit operations.
`define URIO_FN_TEST 6'h00
`define URIO_FN_RESET 6'h20
`define URIO_FN_RDR_STOP 6'h10
`define URIO_FN_IRQ 5
`define URIO_FN_CONT 4
`define URIO_LOW_PRT_ADV 3'h2
`define URIO_LOW_PRT_PRINT 3'h4
`define URIO_LOW_RDR_READ 3'h1
`define URIO_LOW_PUN_PUNCH 3'h4
`define URIO_LOW_PUN_SKIP 3'h6

// Detail bit positions (octal 0100, 0200, 0400, 01000, 02000).
`define URIO_DT_XLATE 6
`define URIO_DT_ADVBASE 7
`define URIO_DT_HALF 8
`define URIO_DT_STK1 9
`define URIO_DT_MANUAL 10

// Indicator bit positions.
`define URIO_IND_PAPER 1
`define URIO_IND_REG 2
`define URIO_IND_TWO 3
`define URIO_IND_MANBTN 4
`define URIO_IND_FED 4
`define URIO_IND_WHEEL 5
`define URIO_IND_SOLAR 5
`define URIO_IND_HOLE 5
`define URIO_IND_PARITY 6
`define URIO_IND_NOTRDY 9
`define URIO_IND_BUSY 10
`define URIO_IND_OVLD 11
`define URIO_VALID_PRT 12'he72
`define URIO_VALID_RDR 12'he7c
`define URIO_VALID_PUN 12'he60

// Control word group numbers.
`define URIO_GRP_PRT_BASE 7'h20
`define URIO_GRP_PRT_ADV 7'h21
`define URIO_GRP_RDR_BASE 7'h24
`define URIO_GRP_RDR_SBY 7'h25
`define URIO_GRP_PUN_BASE 7'h28

// Transfer lengths and base increments in characters.
`define URIO_LEN_FULL 8'h80
`define URIO_LEN_HALF 8'h40
`define URIO_LEN_C80 8'h50
`define URIO_LEN_C160 8'ha0
`define URIO_LEN_C90 8'h5a
`define URIO_INC_128 8'h80
`define URIO_INC_192 8'hc0

// Timing: reader cycle in milliseconds, clock rate in kilohertz.
`define URIO_RDR_CYCLE_MS 60
`define URIO_CLK_KHZ 50000
`define URIO_RDR_CYCLE_CYC (`URIO_RDR_CYCLE_MS * `URIO_CLK_KHZ)

`endif

//--- core/urio_pkg.sv
// Types shared by the unit-record input-output control.
package urio_pkg;

  // Sequencer states of the shared transfer engine.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_AUX,
    ST_ADV,
    ST_RD_BASE,
    ST_XFER,
    ST_RD_SBY,
    ST_WR_BASE,
    ST_FINISH
  } urio_state_t;

  // Peripheral owning the engine.
  typedef enum logic [1:0] {
    UNIT_PRT,
    UNIT_RDR,
    UNIT_PUN
  } urio_unit_t;

endpackage

//--- core/urio_ind_bank.sv
// Sticky indicator bank with selective reset and selective test.
`timescale 1ns/100ps
module urio_ind_bank #(
  parameter int W = 12,
  parameter logic [W-1:0] VALID = '1
) (
  // Clock and synchronised reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Events and software selection
  input wire logic [W-1:0] setVec,
  input wire logic clrEn,
  input wire logic [W-1:0] selMask,
  // State
  output logic [W-1:0] ind_q,
  output logic hit
);
  logic [W-1:0] ind_d;
  logic [W-1:0] clrMask;

  // Only selected bits clear, and a new event beats a clear in one cycle.
  assign clrMask = clrEn ? selMask : '0;
  assign ind_d = ((ind_q & ~clrMask) | setVec) & VALID;
  assign hit = |(ind_q & selMask);

  // Bits stay set until an explicit reset selects them.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ind_q <= '0;
    end else begin
      ind_q <= ind_d;
    end
  end
endmodule // urio_ind_bank

//--- core/urio_cyc_timer.sv
// Free-running cycle timer that pulses once per period while enabled.
`timescale 1ns/100ps
`include "urio_cfg.svh"
module urio_cyc_timer #(
  parameter int CYC = `URIO_RDR_CYCLE_CYC
) (
  // Clock and synchronised reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control and period end
  input wire logic run,
  output logic wrap
);
  localparam int W = (CYC > 1) ? $clog2(CYC) : 1;
  logic [W-1:0] cnt_q;

  // The period end is the last count of the cycle.
  assign wrap = run && (cnt_q == W'(CYC - 1));

  // Stopping the timer restarts the cycle from zero.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (!run || wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // urio_cyc_timer

//--- verification/urio_ctrl_monitor.sv
// Port checker for the unit-record control.
`timescale 1ns/100ps
module urio_ctrl_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Watched ports
  input wire logic instrTaken,
  input wire logic [29:0] instrWord,
  input wire logic testInd43_q,
  input wire logic irqPrt_q,
  input wire logic irqRdr_q,
  input wire logic twReq,
  input wire logic twAck,
  input wire logic [6:0] twGroup,
  input wire logic memReq_q,
  input wire logic memAck,
  input wire logic [17:0] memAddr_q,
  input wire logic [11:0] prtInd,
  input wire logic [11:0] rdrInd,
  input wire logic punStack_q,
  input wire logic [3:0] punOcc_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Fields of the word taken this cycle.
  wire logic tk = instrTaken && instrWord[29:24] == 6'h20;
  wire logic [2:0] ch = instrWord[23:21];
  wire logic [5:0] fn = instrWord[17:12];
  wire logic [11:0] det = instrWord[11:0];
  sequence s_stop;
    tk && ch == 3'h1 && fn == 6'h10;
  endsequence
  a_tw_hold: assert property (twReq && !twAck |=> twReq && $stable(twGroup))
    else $error("control word request dropped");
  a_mem_hold: assert property (memReq_q && !memAck |=>
    memReq_q && $stable(memAddr_q)) else $error("memory request dropped");
  a_ind_sticky: assert property (|($past(rdrInd) & ~rdrInd) |->
    $past(tk && ch == 3'h1 && fn == 6'h20) &&
    ($past(rdrInd) & ~rdrInd & ~$past(det)) == 0)
    else $error("reader indicator lost");
  a_test_sel: assert property (tk && ch == 3'h0 && fn == 6'h00 |=>
    testInd43_q == $past(|(prtInd & det))) else $error("test result");
  a_stop_cyc: assert property (s_stop |=> !irqRdr_q [*3])
    else $error("cyclic request after stop");
  a_irq_pulse: assert property (irqPrt_q |=> !irqPrt_q)
    else $error("printer request too long");
  a_stack_chk: assert property (punStack_q |-> $past(punOcc_q[3]))
    else $error("stacked from empty station");
  a_occ_shift: assert property ($changed(punOcc_q) |->
    punOcc_q[3:1] == $past(punOcc_q[2:0])) else $error("station skip");
endmodule // urio_ctrl_monitor

bind urio_ctrl urio_ctrl_monitor u_mon (.clk_sys, .rst_b, .instrTaken,
  .instrWord, .testInd43_q, .irqPrt_q, .irqRdr_q, .twReq, .twAck, .twGroup,
  .memReq_q, .memAck, .memAddr_q, .prtInd, .rdrInd, .punStack_q, .punOcc_q);

//--- verification/urio_mem_model.sv
// Control word store and character memory facing the control unit.
`timescale 1ns/100ps
`include "urio_cfg.svh"
module urio_mem_model (
  // Clock, reset and pace
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic slow,
  // Control words
  input wire logic twReq,
  input wire logic twWe,
  input wire logic [6:0] twGroup,
  input wire logic [23:0] twWdata,
  output logic [23:0] twRdata,
  output logic twAck,
  // Characters
  input wire logic memReq_q,
  input wire logic [17:0] memAddr_q,
  output logic [5:0] memRdata,
  output logic memAck
);
  logic [23:0] cw [128];
  logic [1:0] pace = 2'h0;
  // Words the program stores before it issues instructions.
  initial begin
    twRdata = 24'h5a5a5a;
    memRdata = 6'h2a;
    cw[`URIO_GRP_PRT_ADV] = 24'h000005;
    cw[`URIO_GRP_PRT_BASE] = 24'h000100;
    cw[`URIO_GRP_RDR_BASE] = 24'h000040;
    cw[`URIO_GRP_RDR_SBY] = 24'h000080;
    cw[`URIO_GRP_PUN_BASE] = 24'h000200;
  end
  // Data churns between answers so a stale sample never looks valid.
  always @(posedge clk_sys) begin
    pace <= pace + 2'h1;
    twAck <= rst_b && twReq && !twAck && (!slow || pace == 2'h3);
    memAck <= rst_b && memReq_q && !memAck && (!slow || pace[0]);
    if (rst_b && twReq && !twAck && (!slow || pace == 2'h3)) begin
      twRdata <= cw[twGroup];
      if (twWe) cw[twGroup] <= twWdata;
    end else twRdata <= ~twRdata;
    memRdata <= memReq_q ? memAddr_q[5:0] : ~memRdata;
  end
endmodule // urio_mem_model

//--- verification/tb_unit_record_io_control.sv
// Bench running instruction sequences through the unit-record control.
`timescale 1ns/100ps
module tb_unit_record_io_control;
  logic clk_sys = 1'b0, rst_b = 1'b0, instrValid = 1'b0, slow = 1'b0;
  logic [29:0] instrWord = '0;
  logic [8:0] flt = '0;
  logic [2:0] rdy = 3'h7;
  logic prtAdvDone = 1'b0, sel = 1'b0;
  logic [5:0] rdrChar = 6'h00, lines = 6'h00, memRdata, prtAdvLines_q;
  logic [23:0] twRdata, twWdata;
  logic [6:0] twGroup;
  logic [17:0] memAddr_q;
  logic [11:0] prtInd, rdrInd;
  logic [3:0] punOcc_q;
  logic instrTaken, procHold, testInd43_q, irqPrt_q, irqRdr_q, twReq, twWe;
  logic twAck, memReq_q, memAck, prtAdvStart_q, prtDataValid, rdrCharReady;
  logic punDataValid, punStack_q, punStackSel1_q;
  int nP, nR, nU, nA, nI, k, err_total = 0, n_tests = 0;
  logic [11:0] dets [6] = '{12'h0, 12'h0, 12'h0, 12'h080, 12'h200, 12'h0};
  urio_ctrl #(.RDR_CYCLE_CYC(50)) u_dut (.clk_sys, .rst_b, .instrValid,
    .instrWord, .instrTaken, .procHold, .testInd43_q, .irqPrt_q, .irqRdr_q,
    .irqPun_q(), .twReq, .twWe, .twGroup, .twWdata, .twRdata, .twAck,
    .memReq_q, .memWe_q(), .memAddr_q, .memWdata_q(), .memRdata, .memAck,
    .memParityErr(flt[0]), .memOverload(flt[1]), .prtReady(rdy[0]),
    .prtPaperLow(flt[2]), .prtManualBtn(flt[3]), .prtWheelErr(flt[4]),
    .prtAdvStart_q, .prtAdvLines_q, .prtAdvDone, .prtDataValid,
    .prtDataReady(1'b1), .rdrReady(rdy[1]), .rdrRegErr(flt[5]),
    .rdrTwoCards(flt[6]), .rdrSolarErr(flt[7]), .rdrFeed_q(), .rdrXlate_q(),
    .rdrChar, .rdrCharValid(1'b1), .rdrCharReady, .punReady(rdy[2]),
    .punHoleErr(flt[8]), .punAdvance_q(), .punXlate_q(), .punDataValid,
    .punDataReady(1'b1), .punStack_q, .punStackSel1_q, .punOcc_q,
    .devData_q(), .prtInd, .rdrInd, .punInd());
  urio_mem_model u_mem (.clk_sys, .rst_b, .slow, .twReq, .twWe, .twGroup,
    .twWdata, .twRdata, .twAck, .memReq_q, .memAddr_q, .memRdata, .memAck);
  initial forever #10 clk_sys = ~clk_sys;
  // Mechanisms answer at once; tallies of what crossed each side.
  always @(posedge clk_sys) begin
    prtAdvDone <= prtAdvStart_q;
    rdrChar <= rdrChar + 6'h01;
    nP <= nP + int'(prtDataValid);
    nR <= nR + int'(rdrCharReady);
    nU <= nU + int'(punDataValid);
    nA <= nA + int'(prtAdvStart_q);
    nI <= nI + int'(irqRdr_q);
    if (prtAdvStart_q) lines <= prtAdvLines_q;
    if (punStack_q) sel <= punStackSel1_q;
  end
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Tallies are cleared off the edge to avoid racing the counters.
  task automatic clr();
    @(negedge clk_sys);
    {nP, nR, nU, nA, nI} = '0;
    @(posedge clk_sys);
  endtask
  task automatic xf(logic [2:0] c, logic [5:0] f, logic [11:0] d);
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= {6'h20, c, 3'h0, f, d};
    do @(negedge clk_sys); while (instrTaken !== 1'b1);
    @(posedge clk_sys);
    instrValid <= 1'b0;
  endtask
  task automatic wdone();
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (procHold !== 1'b0 && k < 4000);
    chk("hold", 0, procHold);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    clr();
    xf(3'h0, 6'h24, 12'h080);
    wdone();
    chk("chars", 128, nP);
    chk("lines", 5, lines);
    chk("base", 24'h180, u_mem.cw[7'h20]);
    clr();
    flt[2] <= 1'b1;
    xf(3'h0, 6'h04, 12'h500);
    wdone();
    chk("half", 64, nP);
    chk("advs", 0, nA);
    chk("base", 24'h180, u_mem.cw[7'h20]);
    xf(3'h0, 6'h00, 12'h002);
    flt[2] <= 1'b0;
    @(negedge clk_sys);
    chk("ind43", 1, testInd43_q);
    xf(3'h0, 6'h20, 12'h002);
    @(negedge clk_sys);
    chk("paper", 0, prtInd[1]);
    $display("printer done");
    clr();
    slow <= 1'b1;
    xf(3'h1, 6'h21, 12'h000);
    wdone();
    chk("rchars", 160, nR);
    chk("rbase", 24'h80, u_mem.cw[7'h24]);
    clr();
    repeat (200) @(negedge clk_sys);
    chk("cyclic", 1, nI >= 3);
    xf(3'h1, 6'h10, 12'h0c0);
    clr();
    repeat (200) @(negedge clk_sys);
    chk("stop", 0, nI);
    clr();
    xf(3'h1, 6'h01, 12'h0c0);
    wdone();
    chk("xchars", 80, nR);
    chk("rbase", 24'h100, u_mem.cw[7'h24]);
    @(posedge clk_sys);
    flt[7:5] <= 3'h5;
    @(posedge clk_sys);
    flt[7:5] <= 3'h0;
    @(negedge clk_sys);
    chk("rind", 12'h024, rdrInd & 12'h02c);
    xf(3'h1, 6'h20, 12'h024);
    @(negedge clk_sys);
    chk("rclr", 0, rdrInd & 12'h02c);
    $display("reader done");
    for (int i = 0; i < 6; i++) begin
      clr();
      xf(3'h2, 6'h04, dets[i]);
      wdone();
      if (i == 3) begin
        chk("occ", 4'hf, punOcc_q);
        chk("pchars", 160, nU);
        chk("pbase", 24'h2a0, u_mem.cw[7'h28]);
      end
      if (i > 3) chk("stack", i == 4, sel);
    end
    $display("punch done");
    summarize();
  end
endmodule // tb_unit_record_io_control
